//--- hdl/plcd_pkg.sv
package plcd_pkg;
    // Serial word layout.
    localparam int unsigned WORD_W       = 16;
    localparam int unsigned SAMPLE_W     = 12;
    localparam int unsigned ADDR_W       = 7;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned RW_POS       = 15;
    localparam int unsigned ADDR_LSB     = 8;
    // Register map.
    localparam logic [6:0] ADDR_CLK_DIV  = 7'h01;
    localparam logic [6:0] ADDR_STATUS   = 7'h02;
    localparam logic [6:0] ADDR_ANALOG   = 7'h03;
    localparam logic [7:0] CLK_DIV_RST   = 8'h00;
    localparam logic [7:0] ANALOG_RST    = 8'h00;
    localparam int unsigned FIRST_LSB    = 4;
    localparam int unsigned SECOND_LSB   = 0;
    localparam int unsigned DIV_FIELD_W  = 4;
    localparam int unsigned ST_MODE_POS  = 7;
    localparam int unsigned ST_EMPTY_POS = 6;
    localparam int unsigned ST_FULL_POS  = 5;
    localparam int unsigned ST_DROP_POS  = 4;
    // Converter code at mid-scale and sign flip to offset binary.
    localparam logic [11:0] CODE_MID     = 12'h000;
    localparam logic [11:0] SIGN_FLIP    = 12'h800;
    // Timing.
    localparam longint SYS_CLK_HZ        = 125000000;
    localparam longint SCLK_MAX_HZ       = 30000000;
    localparam int unsigned SCLK_HALF    =
        int'((SYS_CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ));
    localparam int unsigned REF_HALF     = 2;
    localparam int unsigned MAX_DIV      = 256;
    localparam int unsigned ENTRY_CONV   = 20;
    localparam int unsigned GAP_CONV     = 10;
    localparam int unsigned ENTRY_CYCLES = ENTRY_CONV * MAX_DIV * 2 * REF_HALF;
    localparam int unsigned GAP_CYCLES   = GAP_CONV * MAX_DIV * 2 * REF_HALF;
    localparam int unsigned FIFO_DEPTH   = 8;
endpackage

//--- hdl/plcd_link_if.sv
interface plcd_link_if;
    logic chipSelN;
    logic sclk;
    logic din;
    logic dout;
    logic doutOe;
    logic doutLine;
    logic sampleMode;
    logic reference_clock_in;

    // Undriven line reads high through the board pull-up.
    assign doutLine = doutOe ? dout : 1'b1;

    modport dev (
        input  chipSelN,
        input  sclk,
        input  din,
        output dout,
        output doutOe,
        input  sampleMode,
        input  reference_clock_in
    );
    modport host (
        output chipSelN,
        output sclk,
        output din,
        input  doutLine,
        output sampleMode,
        output reference_clock_in
    );
endinterface

//--- hdl/plcd_fifo.sv
module plcd_fifo #(
    parameter int unsigned W     = 12,
    parameter int unsigned DEPTH = 8
) (
    // Clock and reset.
    input  wire logic         sysClk,
    input  wire logic         rst,
    // Fill side.
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    // Drain side.
    output logic              outValid,
    input  wire logic         outReady,
    output logic [W-1:0]      outData
);
    localparam int unsigned PW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];
    logic [PW:0]  wrPtr_q;
    logic [PW:0]  rdPtr_q;
    wire          doPush = inValid && inReady;
    wire          doPop  = outValid && outReady;

    assign inReady  = (wrPtr_q - rdPtr_q) != (PW+1)'(DEPTH);
    assign outValid = wrPtr_q != rdPtr_q;
    assign outData  = mem[rdPtr_q[PW-1:0]];

    always_ff @(posedge sysClk) begin
        if (doPush) begin
            mem[wrPtr_q[PW-1:0]] <= inData;
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            wrPtr_q <= wrPtr_q + (PW+1)'(doPush);
            rdPtr_q <= rdPtr_q + (PW+1)'(doPop);
        end
    end
endmodule

//--- hdl/plcd_device.sv
module plcd_device #(
    parameter int unsigned FIFO_DEPTH = plcd_pkg::FIFO_DEPTH
) (
    // Clock and reset.
    input  wire logic   sysClk,
    input  wire logic   rst,
    // Serial link.
    plcd_link_if.dev    link,
    // Converter side.
    output logic [11:0] convLevel,
    output logic        convUpdate,
    // Configuration and flow.
    output logic [7:0]  analogCtrl,
    output logic        sampleBackpressure
);
    localparam int unsigned SW = plcd_pkg::SAMPLE_W;
    localparam int unsigned WW = plcd_pkg::WORD_W;

    // Pin edge detection; inputs are synchronous to sysClk.
    logic sclkPrev_q;
    logic csPrev_q;
    logic refPrev_q;
    wire  sclkRise = link.sclk && !sclkPrev_q;
    wire  sclkFall = !link.sclk && sclkPrev_q;
    wire  csFall   = !link.chipSelN && csPrev_q;
    wire  csRise   = link.chipSelN && !csPrev_q;
    wire  refRise  = link.reference_clock_in && !refPrev_q;

    // Serial slave state.
    logic [WW-1:0] inShift_q;
    logic [4:0]    bitCnt_q;
    logic [WW-1:0] outShift_q;
    logic          dout_q;
    logic          doutOe_q;
    logic          prevRw_q;
    logic [6:0]    prevAddr_q;
    logic [7:0]    prevData_q;

    // Registers.
    logic [7:0]    clkDiv_q;
    logic [7:0]    analog_q;
    logic          drop_q;

    // Divider and converter state.
    logic [3:0]    stage1Cnt_q;
    logic [3:0]    stage2Cnt_q;
    logic [11:0]   convLevel_q;
    logic          convUpdate_q;
    logic          backp_q;

    // FIFO wiring.
    logic          fifoInReady;
    logic          fifoOutValid;
    logic [SW-1:0] fifoOutData;

    wire  sampleModeNow = link.sampleMode;

    function automatic logic [7:0] readReg(input logic [6:0] addr,
                                           input logic [7:0] div,
                                           input logic [7:0] ana,
                                           input logic [7:0] st);
        if (addr == plcd_pkg::ADDR_CLK_DIV) begin
            readReg = div;
        end else if (addr == plcd_pkg::ADDR_STATUS) begin
            readReg = st;
        end else if (addr == plcd_pkg::ADDR_ANALOG) begin
            readReg = ana;
        end else begin
            readReg = 8'h00;
        end
    endfunction

    // Status byte shows live block state.
    wire [7:0] statusByte = {sampleModeNow, !fifoOutValid, !fifoInReady, drop_q, 4'h0};

    // Word returned during the next command.
    wire [7:0]    prevRead = readReg(prevAddr_q, clkDiv_q, analog_q, statusByte);
    wire [WW-1:0] replyWord = {prevRw_q, prevAddr_q, prevRw_q ? prevRead : prevData_q};

    // Received command fields.
    wire          cmdRw   = inShift_q[plcd_pkg::RW_POS];
    wire [6:0]    cmdAddr = inShift_q[plcd_pkg::ADDR_LSB +: plcd_pkg::ADDR_W];
    wire [7:0]    cmdData = inShift_q[plcd_pkg::DATA_W-1:0];
    wire          cmdDone = csRise && !sampleModeNow && bitCnt_q == 5'(WW);
    wire          cmdWrite = cmdDone && !cmdRw;

    // Sample capture: first 12 bits, left-justified within the frame.
    wire          smpDone = csRise && sampleModeNow && bitCnt_q >= 5'(SW);
    wire [SW-1:0] smpWord = (bitCnt_q == 5'(SW)) ? inShift_q[SW-1:0]
                                                 : inShift_q[WW-1 -: SW];
    wire          smpDrop = smpDone && !fifoInReady;
    wire          dropClr = cmdWrite && cmdAddr == plcd_pkg::ADDR_STATUS
                            && cmdData[plcd_pkg::ST_DROP_POS];

    // Divider stages count reference edges.
    wire [3:0] firstN  = clkDiv_q[plcd_pkg::FIRST_LSB +: plcd_pkg::DIV_FIELD_W];
    wire [3:0] secondN = clkDiv_q[plcd_pkg::SECOND_LSB +: plcd_pkg::DIV_FIELD_W];
    wire       stage1Tick = refRise && stage1Cnt_q >= firstN;
    wire       convTick   = stage1Tick && stage2Cnt_q >= secondN;

    // Converter pops at most one sample per converter tick.
    wire       popSample = convTick && fifoOutValid;

    always_ff @(posedge sysClk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
            csPrev_q   <= 1'b1;
            refPrev_q  <= 1'b0;
        end else begin
            sclkPrev_q <= link.sclk;
            csPrev_q   <= link.chipSelN;
            refPrev_q  <= link.reference_clock_in;
        end
    end

    // Serial receiver runs on chip select falls and serial clock rises only.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            inShift_q <= '0;
            bitCnt_q  <= '0;
        end else if (csFall) begin
            bitCnt_q  <= '0;
        end else if (sclkRise && !link.chipSelN) begin
            inShift_q <= {inShift_q[WW-2:0], link.din};
            bitCnt_q  <= (bitCnt_q == 5'(WW)) ? bitCnt_q : bitCnt_q + 5'd1;
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            outShift_q <= '0;
            dout_q     <= 1'b0;
            doutOe_q   <= 1'b0;
        end else if (csFall && !sampleModeNow) begin
            dout_q     <= replyWord[WW-1];
            outShift_q <= {replyWord[WW-2:0], 1'b0};
            doutOe_q   <= 1'b1;
        end else if (link.chipSelN || sampleModeNow) begin
            doutOe_q   <= 1'b0;
        end else if (sclkFall) begin
            dout_q     <= outShift_q[WW-1];
            outShift_q <= {outShift_q[WW-2:0], 1'b0};
        end
    end

    // Command execution at the end of a full command word.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            prevRw_q   <= 1'b0;
            prevAddr_q <= '0;
            prevData_q <= '0;
            clkDiv_q   <= plcd_pkg::CLK_DIV_RST;
            analog_q   <= plcd_pkg::ANALOG_RST;
        end else if (cmdDone) begin
            prevRw_q   <= cmdRw;
            prevAddr_q <= cmdAddr;
            prevData_q <= cmdData;
            if (cmdWrite && cmdAddr == plcd_pkg::ADDR_CLK_DIV) begin
                clkDiv_q <= cmdData;
            end else if (cmdWrite && cmdAddr == plcd_pkg::ADDR_ANALOG) begin
                analog_q <= cmdData;
            end
        end
    end

    // Dropped-sample flag: a new drop wins over a clear.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            drop_q <= 1'b0;
        end else if (smpDrop) begin
            drop_q <= 1'b1;
        end else if (dropClr) begin
            drop_q <= 1'b0;
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            stage1Cnt_q <= '0;
            stage2Cnt_q <= '0;
        end else if (refRise) begin
            stage1Cnt_q <= stage1Tick ? 4'd0 : stage1Cnt_q + 4'd1;
            if (stage1Tick) begin
                stage2Cnt_q <= convTick ? 4'd0 : stage2Cnt_q + 4'd1;
            end
        end
    end

    // Converter output holds its last value when no sample arrives.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            convLevel_q  <= plcd_pkg::CODE_MID ^ plcd_pkg::SIGN_FLIP;
            convUpdate_q <= 1'b0;
            backp_q      <= 1'b0;
        end else begin
            convUpdate_q <= convTick;
            backp_q      <= !fifoInReady;
            if (popSample) begin
                convLevel_q <= fifoOutData ^ plcd_pkg::SIGN_FLIP;
            end
        end
    end

    plcd_fifo #(
        .W     (SW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sysClk   (sysClk),
        .rst      (rst),
        .inValid  (smpDone),
        .inReady  (fifoInReady),
        .inData   (smpWord),
        .outValid (fifoOutValid),
        .outReady (convTick),
        .outData  (fifoOutData)
    );

    assign link.dout          = dout_q;
    assign link.doutOe        = doutOe_q;
    assign convLevel          = convLevel_q;
    assign convUpdate         = convUpdate_q;
    assign analogCtrl         = analog_q;
    assign sampleBackpressure = backp_q;
endmodule

//--- hdl/plcd_host.sv
module plcd_host #(
    parameter int unsigned ENTRY_CYCLES = plcd_pkg::ENTRY_CYCLES,
    parameter int unsigned GAP_CYCLES   = plcd_pkg::GAP_CYCLES
) (
    // Clock and reset.
    input  wire logic   sysClk,
    input  wire logic   rst,
    // Serial link.
    plcd_link_if.host   link,
    // Command port.
    input  wire logic        cmdValid,
    output logic             cmdReady,
    input  wire logic [15:0] cmdWord,
    output logic             rspValid,
    output logic [15:0]      rspWord,
    // Sample port.
    input  wire logic        modeReq,
    input  wire logic        smpValid,
    output logic             smpReady,
    input  wire logic [11:0] smpData,
    output logic             modeActive
);
    typedef enum logic [2:0] {
        H_IDLE  = 3'b000,
        H_SHIFT = 3'b001,
        H_GAP   = 3'b010,
        H_ENTRY = 3'b011,
        H_EXIT  = 3'b100
    } plcd_hstate_t;

    plcd_hstate_t state_q;
    logic [15:0]  tx_q;
    logic [15:0]  rx_q;
    logic [4:0]   bitCnt_q;
    logic [4:0]   lastBit_q;
    logic [1:0]   halfCnt_q;
    logic [31:0]  waitCnt_q;
    logic         cs_q;
    logic         sclk_q;
    logic         mode_q;
    logic         isCmd_q;
    logic         rspValid_q;
    logic         cmdReady_q;
    logic         smpReady_q;
    logic [1:0]   refCnt_q;
    logic         ref_q;

    wire halfDone = halfCnt_q == 2'(plcd_pkg::SCLK_HALF - 1);
    wire takeCmd  = state_q == H_IDLE && cmdValid && cmdReady_q;
    wire takeSmp  = state_q == H_IDLE && smpValid && smpReady_q;
    wire lastEdge = state_q == H_SHIFT && halfDone && sclk_q && bitCnt_q == lastBit_q;

    // Free-running reference clock, 50/50 from sysClk.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            refCnt_q <= '0;
            ref_q    <= 1'b0;
        end else if (refCnt_q == 2'(plcd_pkg::REF_HALF - 1)) begin
            refCnt_q <= '0;
            ref_q    <= !ref_q;
        end else begin
            refCnt_q <= refCnt_q + 2'd1;
        end
    end

    always_ff @(posedge sysClk) begin
        if (rst) begin
            state_q    <= H_IDLE;
            tx_q       <= '0;
            rx_q       <= '0;
            bitCnt_q   <= '0;
            lastBit_q  <= '0;
            halfCnt_q  <= '0;
            waitCnt_q  <= '0;
            cs_q       <= 1'b1;
            sclk_q     <= 1'b0;
            mode_q     <= 1'b0;
            isCmd_q    <= 1'b0;
            rspValid_q <= 1'b0;
        end else begin
            rspValid_q <= 1'b0;
            case (state_q)
                H_IDLE: begin
                    halfCnt_q <= '0;
                    bitCnt_q  <= '0;
                    if (takeCmd || takeSmp) begin
                        tx_q      <= takeCmd ? cmdWord : {smpData, 4'h0};
                        lastBit_q <= takeCmd ? 5'd15 : 5'd11;
                        isCmd_q   <= takeCmd;
                        cs_q      <= 1'b0;
                        state_q   <= H_SHIFT;
                    end else if (modeReq && !mode_q) begin
                        cs_q      <= 1'b0;
                        waitCnt_q <= '0;
                        state_q   <= H_ENTRY;
                    end else if (!modeReq && mode_q) begin
                        waitCnt_q <= '0;
                        state_q   <= H_EXIT;
                    end
                end
                H_SHIFT: begin
                    halfCnt_q <= halfDone ? 2'd0 : halfCnt_q + 2'd1;
                    if (halfDone && !sclk_q) begin
                        sclk_q <= 1'b1;
                        rx_q   <= {rx_q[14:0], link.doutLine};
                    end else if (halfDone) begin
                        sclk_q <= 1'b0;
                        if (lastEdge) begin
                            cs_q       <= 1'b1;
                            rspValid_q <= isCmd_q;
                            waitCnt_q  <= '0;
                            state_q    <= H_GAP;
                        end else begin
                            tx_q     <= {tx_q[14:0], 1'b0};
                            bitCnt_q <= bitCnt_q + 5'd1;
                        end
                    end
                end
                H_GAP: begin
                    waitCnt_q <= waitCnt_q + 32'd1;
                    if (waitCnt_q >= GAP_CYCLES - 1) begin
                        state_q <= H_IDLE;
                    end
                end
                H_ENTRY: begin
                    waitCnt_q <= waitCnt_q + 32'd1;
                    if (waitCnt_q >= ENTRY_CYCLES - 1) begin
                        mode_q    <= 1'b1;
                        cs_q      <= 1'b1;
                        waitCnt_q <= '0;
                        state_q   <= H_GAP;
                    end
                end
                H_EXIT: begin
                    waitCnt_q <= waitCnt_q + 32'd1;
                    if (waitCnt_q >= ENTRY_CYCLES - 1) begin
                        mode_q  <= 1'b0;
                        state_q <= H_IDLE;
                    end
                end
                default: begin
                    state_q <= H_IDLE;
                end
            endcase
        end
    end

    // Ready flags look one cycle ahead so handshakes stay honest.
    always_ff @(posedge sysClk) begin
        if (rst) begin
            cmdReady_q <= 1'b0;
            smpReady_q <= 1'b0;
        end else begin
            cmdReady_q <= state_q == H_IDLE && !takeCmd && !takeSmp && !mode_q && !modeReq;
            smpReady_q <= state_q == H_IDLE && !takeCmd && !takeSmp && mode_q && modeReq;
        end
    end

    assign link.chipSelN          = cs_q;
    assign link.sclk              = sclk_q;
    assign link.din               = tx_q[15];
    assign link.sampleMode        = mode_q;
    assign link.reference_clock_in = ref_q;
    assign cmdReady   = cmdReady_q;
    assign smpReady   = smpReady_q;
    assign rspValid   = rspValid_q;
    assign rspWord    = rx_q;
    assign modeActive = mode_q;
endmodule

//--- tb/plcd_link_properties.sv
module plcd_link_properties #(
    parameter int unsigned ENTRY_CYCLES = plcd_pkg::ENTRY_CYCLES
) (
    // Clock and reset.
    input wire logic sysClk,
    input wire logic rst,
    // Link signals.
    input wire logic chipSelN,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic doutOe,
    input wire logic doutLine,
    input wire logic sampleMode,
    input wire logic reference_clock_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sclk_q;
    logic [4:0]  bitCnt_q;
    logic [7:0]  hiCnt_q;
    logic [15:0] loCnt_q;
    wire  [4:0]  bitCnt_d = chipSelN ? 5'h00 : bitCnt_q + {4'h0, sclk & ~sclk_q};
    wire  [7:0]  hiCnt_d  = rst ? 8'hff : !chipSelN ? 8'h00 : hiCnt_q + {7'h00, ~&hiCnt_q};
    wire  [15:0] loCnt_d  = chipSelN ? 16'h0000 : loCnt_q + {15'h0000, ~&loCnt_q};

    always_ff @(posedge sysClk) begin
        sclk_q   <= sclk;
        bitCnt_q <= bitCnt_d;
        hiCnt_q  <= hiCnt_d;
        loCnt_q  <= loCnt_d;
    end

    default clocking cb @(posedge sysClk); endclocking
    default disable iff (rst);

    AST_SCLK_GATED: assert property (sclk |-> !chipSelN)
        else $error("serial clock high outside a frame");
    AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk [*3] ##1 !sclk)
        else $error("serial clock high phase has the wrong length");
    AST_REF_SHAPE: assert property ($rose(reference_clock_in) |->
        reference_clock_in [*2] ##1 !reference_clock_in [*2] ##1 reference_clock_in)
        else $error("reference clock is not two high and two low");
    AST_DIN_HELD: assert property (sclk && $past(sclk) |-> $stable(din))
        else $error("data changed while serial clock high");
    AST_FRAME_BITS: assert property ($rose(chipSelN) && bitCnt_q != 5'h00 |->
        bitCnt_q == (sampleMode ? 5'h0c : 5'h10))
        else $error("frame carried a wrong number of bits");
    AST_FRAME_GAP: assert property ($fell(chipSelN) |-> hiCnt_q >= 8'h18)
        else $error("select high gap too short");
    AST_MODE_ENTRY: assert property ($rose(sampleMode) |-> loCnt_q >= ENTRY_CYCLES - 2)
        else $error("sample mode entered without the select low wait");
    AST_DOUT_RELEASE: assert property (chipSelN [*4] |-> !doutOe && doutLine)
        else $error("reply line driven outside a frame");
    AST_SAMPLE_QUIET: assert property (sampleMode && $past(sampleMode, 4) |-> !doutOe)
        else $error("reply line driven in sample mode");

    cover property ($rose(sampleMode));
    cover property ($fell(sampleMode));
    cover property ($rose(chipSelN) && bitCnt_q == 5'h10);
    cover property ($rose(chipSelN) && bitCnt_q == 5'h0c);
endmodule

//--- tb/tb_plc_sample_port_clock_divider.sv
module tb_plc_sample_port_clock_divider;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] DIVS [4] = '{8'h0f, 8'h70, 8'hff, 8'h12};
    localparam int unsigned GAP   = 256;
    localparam int unsigned ENTRY = 512;
    logic        sysClk, rst, cmdValid, cmdReady, rspValid, modeReq, smpValid, smpReady;
    logic        modeActive, convUpdate, sampleBackpressure, pRw, pValid, rw;
    logic [15:0] cmdWord, rspWord;
    logic [11:0] smpData, convLevel;
    logic [11:0] codes [8];
    logic [7:0]  analogCtrl, div, ana, stat, pData;
    logic [6:0]  pAddr, a;
    int          failCount, checked, n, r;

    plcd_link_if plcd_link_if_inst ();
    plcd_host #(.ENTRY_CYCLES(ENTRY), .GAP_CYCLES(GAP)) plcd_host_inst (
        .sysClk(sysClk), .rst(rst), .link(plcd_link_if_inst), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdWord(cmdWord), .rspValid(rspValid), .rspWord(rspWord),
        .modeReq(modeReq), .smpValid(smpValid), .smpReady(smpReady), .smpData(smpData),
        .modeActive(modeActive));
    plcd_device plcd_device_inst (
        .sysClk(sysClk), .rst(rst), .link(plcd_link_if_inst), .convLevel(convLevel),
        .convUpdate(convUpdate), .analogCtrl(analogCtrl),
        .sampleBackpressure(sampleBackpressure));
    plcd_link_properties #(.ENTRY_CYCLES(ENTRY)) plcd_link_properties_inst (
        .sysClk(sysClk), .rst(rst), .chipSelN(plcd_link_if_inst.chipSelN),
        .sclk(plcd_link_if_inst.sclk), .din(plcd_link_if_inst.din),
        .dout(plcd_link_if_inst.dout), .doutOe(plcd_link_if_inst.doutOe),
        .doutLine(plcd_link_if_inst.doutLine), .sampleMode(plcd_link_if_inst.sampleMode),
        .reference_clock_in(plcd_link_if_inst.reference_clock_in));

    always #4 sysClk = ~sysClk;

    task automatic stopTest();
        if (failCount == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chkWord(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            failCount++;
            $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic chkCount(input int got, input int exp);
        checked++;
        if (got != exp) begin
            failCount++;
            $display("unexpected at %0t: period %0d, wanted %0d", $time, got, exp);
        end
    endtask

    task automatic waitFor(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        do begin
            @(negedge sysClk);
            k++;
        end while (s !== v && k < lim);
        if (s !== v) begin
            failCount++;
            $display("unexpected at %0t: wait ran out", $time);
        end
    endtask

    function automatic logic [7:0] regRead(input logic [6:0] ad);
        return ad == 7'h01 ? div : ad == 7'h03 ? ana : ad == 7'h02 ? stat : 8'h00;
    endfunction

    // Offset binary level expected for a two's complement code.
    function automatic logic [11:0] lvl(input logic [11:0] c);
        return {~c[11], c[10:0]};
    endfunction

    // The reply of a command echoes the previous command, with the register value in place of the data for a read.
    task automatic cmd(input logic w, input logic [6:0] ad, input logic [7:0] d);
        logic [15:0] exp;
        exp = {pRw, pAddr, pRw ? regRead(pAddr) : pData};
        @(posedge sysClk);
        cmdValid <= 1'b1;
        cmdWord  <= {w, ad, d};
        waitFor(cmdReady, 1'b1, 30000);
        @(posedge sysClk);
        cmdValid <= 1'b0;
        waitFor(rspValid, 1'b1, 400);
        if (pValid) chkWord(rspWord, exp);
        pValid = 1'b1;
        pRw    = w;
        pAddr  = ad;
        pData  = d;
        if (!w && ad == 7'h01) div = d;
        if (!w && ad == 7'h03) ana = d;
    endtask

    task automatic smp(input logic [11:0] c);
        @(posedge sysClk);
        smpValid <= 1'b1;
        smpData  <= c;
        waitFor(smpReady, 1'b1, 2000);
        @(posedge sysClk);
        smpValid <= 1'b0;
    endtask

    task automatic period(input int exp);
        waitFor(convUpdate, 1'b1, 2100);
        waitFor(convUpdate, 1'b1, 2100);
        n = 0;
        do begin
            @(negedge sysClk);
            n++;
        end while (convUpdate !== 1'b1 && n < 2100);
        chkCount(n, exp);
    endtask

    initial begin
        #400000;
        failCount++;
        $display("unexpected at %0t: run timed out", $time);
        stopTest();
    end

    initial begin
        sysClk = 1'b0;
        rst = 1'b1;
        cmdValid = 1'b0;
        cmdWord = 16'h0000;
        modeReq = 1'b0;
        smpValid = 1'b0;
        smpData = 12'h000;
        {failCount, checked} = '0;
        {div, ana, stat, pData, pAddr, pRw, pValid} = '0;
        void'($urandom(44));
        codes = '{12'h7ff, 12'h000, 12'hfff, 12'h800, 12'h000, 12'h000, 12'h000, 12'h000};
        for (int i = 4; i < 8; i++) codes[i] = 12'($urandom);
        repeat (4) @(posedge sysClk);
        rst <= 1'b0;
        @(negedge sysClk);
        chkWord({4'h0, convLevel}, 16'h0800);
        chkWord({8'h00, analogCtrl}, 16'h0000);
        period(4);
        cmd(1'b1, 7'h01, 8'h00);
        cmd(1'b1, 7'h01, 8'h00);
        foreach (DIVS[i]) begin
            cmd(1'b0, 7'h01, DIVS[i]);
            period(4 * (DIVS[i][7:4] + 1) * (DIVS[i][3:0] + 1));
        end
        repeat (12) begin
            rw = 1'($urandom_range(0, 1));
            r  = $urandom_range(0, 2);
            a  = (r == 0 || (r == 1 && !rw)) ? 7'h03 : (r == 1) ? 7'h01 : 7'($urandom_range(4, 127));
            cmd(rw, a, 8'($urandom));
        end
        cmd(1'b1, 7'h03, 8'h00);
        chkWord({8'h00, analogCtrl}, {8'h00, ana});
        @(posedge sysClk);
        modeReq <= 1'b1;
        waitFor(modeActive, 1'b1, 22000);
        chkWord({4'h0, convLevel}, 16'h0800);
        foreach (codes[i]) begin
            smp(codes[i]);
            n = 0;
            while (convLevel !== lvl(codes[i]) && n < 1500) begin
                @(negedge sysClk);
                n++;
            end
            chkWord({4'h0, convLevel}, {4'h0, lvl(codes[i])});
        end
        repeat (2100) @(negedge sysClk);
        chkWord({4'h0, convLevel}, {4'h0, lvl(codes[7])});
        repeat (16) smp(12'($urandom));
        chkWord({15'h0000, sampleBackpressure}, 16'h0000);
        repeat (9316) @(negedge sysClk);
        chkWord({15'h0000, sampleBackpressure}, 16'h0000);
        @(posedge sysClk);
        modeReq <= 1'b0;
        waitFor(modeActive, 1'b0, 22000);
        stat = 8'h40;
        cmd(1'b1, 7'h02, 8'h00);
        cmd(1'b1, 7'h02, 8'h00);
        stopTest();
    end
endmodule
